// [rtl/eee_np_pkg.sv]
// Constants for the EEE next page indirect register bank.
// Assumes a byte-wide switch register port on the core clock.
package eee_np_pkg;
	localparam int NUM_PORTS = 4;
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	// Direct register addresses
	localparam logic [7:0] ADDR_SPACE_PORT = 8'h6E;
	localparam logic [7:0] ADDR_BYTE_OFFSET = 8'h6F;
	localparam logic [7:0] ADDR_DATA_BYTE = 8'hA0;
	// Control byte fields
	localparam int SPACE_HI = 7;
	localparam int SPACE_LO = 5;
	localparam int PORT_HI = 3;
	localparam logic [2:0] SPACE_EEE = 3'h1;
	localparam logic [3:0] PORT_FIRST = 4'h1;
	localparam logic [3:0] PORT_LAST = 4'h4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET = 8'h00;
	// Indirect byte offsets
	localparam logic [7:0] OFS_TX_HI = 8'h0E;
	localparam logic [7:0] OFS_TX_LO = 8'h0F;
	localparam logic [7:0] OFS_RX_HI = 8'h10;
	localparam logic [7:0] OFS_RX_LO = 8'h11;
	// Next page word fields
	localparam int MORE_BIT = 15;
	localparam int TYPE_BIT = 13;
	localparam int COMPLY_BIT = 12;
	localparam int TOGGLE_BIT = 11;
	localparam int CODE_W = 11;
	localparam int HI_BASE = 8;
	localparam logic RESET_MORE = 1'b0;
	localparam logic RESET_TYPE = 1'b1;
	localparam logic RESET_COMPLY = 1'b0;
	localparam logic RESET_TOGGLE = 1'b0;
	localparam logic RESERVED_VAL = 1'b0;
	localparam logic [10:0] RESET_CODE = 11'h001;
	localparam logic [15:0] TX_RESET = 16'h2001;
	localparam logic [15:0] RX_RESET = 16'h0000;
	localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : eee_np_pkg

// [rtl/np_port_if.sv]
// Bundle between the indirect access decoder and one port's registers.
// Carries byte write strobes down and both 16-bit words back up.
`timescale 1ns/100ps
`default_nettype none
interface np_port_if;
	logic wr_hi;
	logic wr_lo;
	logic [7:0] wdata;
	logic [15:0] tx_word;
	logic [15:0] rx_word;
	modport bank (output wr_hi, output wr_lo, output wdata,
		input tx_word, input rx_word);
	modport port (input wr_hi, input wr_lo, input wdata,
		output tx_word, output rx_word);
endinterface : np_port_if
`default_nettype wire

// [rtl/np_port_regs.sv]
// One port's next page transmit and partner next page receive words.
// Assumes strobes and negotiation events come from the core clock domain.
`timescale 1ns/100ps
`default_nettype none
module np_port_regs (
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	np_port_if.port bus,
	input wire logic base_sent,
	input wire logic base_toggle,
	input wire logic page_sent,
	input wire logic partner_load,
	input wire logic [eee_np_pkg::WORD_W-1:0] partner_word
);
	import eee_np_pkg::*;

	logic more_q;
	logic type_q;
	logic comply_q;
	logic toggle_q;
	logic [CODE_W-1:0] code_q;
	logic [WORD_W-1:0] rx_q;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			more_q <= RESET_MORE;
			type_q <= RESET_TYPE;
			comply_q <= RESET_COMPLY;
		end else if (ce && bus.wr_hi) begin
			more_q <= bus.wdata[MORE_BIT-HI_BASE];
			type_q <= bus.wdata[TYPE_BIT-HI_BASE];
			comply_q <= bus.wdata[COMPLY_BIT-HI_BASE];
		end
	end

	// Code field straddles both bytes; each half written on its own
	always_ff @(posedge clock) begin
		if (!rstn) begin
			code_q <= RESET_CODE;
		end else if (ce) begin
			if (bus.wr_hi) begin
				code_q[CODE_W-1:HI_BASE] <= bus.wdata[CODE_W-1-HI_BASE:0];
			end
			if (bus.wr_lo) begin
				code_q[HI_BASE-1:0] <= bus.wdata;
			end
		end
	end

	// Software cannot write the toggle; base page exchange wins over next
	always_ff @(posedge clock) begin
		if (!rstn) begin
			toggle_q <= RESET_TOGGLE;
		end else if (ce) begin
			if (base_sent) begin
				toggle_q <= ~base_toggle;
			end else if (page_sent) begin
				toggle_q <= ~toggle_q;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			rx_q <= RX_RESET;
		end else if (ce && partner_load) begin
			rx_q <= partner_word;
		end
	end

	assign bus.tx_word = {more_q, RESERVED_VAL, type_q, comply_q, toggle_q,
		code_q};
	assign bus.rx_word = rx_q;

	property p_first_toggle;
		@(posedge clock) disable iff (!rstn)
		(ce && base_sent) |=> (bus.tx_word[TOGGLE_BIT] == !$past(base_toggle));
	endproperty
	a_first_toggle: assert property (p_first_toggle)
		else $error("toggle not inverse of base page bit");

	property p_toggle_flip;
		@(posedge clock) disable iff (!rstn)
		(ce && page_sent && !base_sent) |=>
			(bus.tx_word[TOGGLE_BIT] != $past(bus.tx_word[TOGGLE_BIT]));
	endproperty
	a_toggle_flip: assert property (p_toggle_flip)
		else $error("toggle did not flip after page exchange");

	property p_toggle_hold;
		@(posedge clock) disable iff (!rstn)
		(!(ce && (page_sent || base_sent))) |=> $stable(bus.tx_word[TOGGLE_BIT]);
	endproperty
	a_toggle_hold: assert property (p_toggle_hold)
		else $error("toggle changed without an exchange");

	property p_reserved_zero;
		@(posedge clock) disable iff (!rstn)
		1'b1 |-> (bus.tx_word[TOGGLE_BIT+3] == RESERVED_VAL);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bit not zero");
endmodule : np_port_regs
`default_nettype wire

// [rtl/eee_np_indirect.sv]
// Indirect access bank for the per-port EEE next page registers.
// Assumes a byte register port on the core clock, single-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
module eee_np_indirect (
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [eee_np_pkg::BYTE_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [eee_np_pkg::BYTE_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [eee_np_pkg::NUM_PORTS-1:0] base_sent,
	input wire logic [eee_np_pkg::NUM_PORTS-1:0] base_toggle,
	input wire logic [eee_np_pkg::NUM_PORTS-1:0] page_sent,
	input wire logic [eee_np_pkg::NUM_PORTS-1:0] partner_load,
	input wire logic [eee_np_pkg::NUM_PORTS*eee_np_pkg::WORD_W-1:0] partner_word,
	output logic [eee_np_pkg::NUM_PORTS*eee_np_pkg::WORD_W-1:0] tx_page
);
	import eee_np_pkg::*;

	logic [BYTE_W-1:0] ctrl_q;
	logic [BYTE_W-1:0] offset_q;
	logic [BYTE_W-1:0] rdata_q;
	logic [BYTE_W-1:0] rdata_d;
	logic rvalid_q;
	logic space_ok;
	logic port_ok;
	logic [3:0] port_sel;
	logic data_wr;
	logic [BYTE_W-1:0] indirect_byte;
	logic [WORD_W-1:0] tx_words [NUM_PORTS];
	logic [WORD_W-1:0] rx_words [NUM_PORTS];
	logic [WORD_W-1:0] sel_tx;
	logic [WORD_W-1:0] sel_rx;
	logic [NUM_PORTS*WORD_W-1:0] tx_fields;

	np_port_if pif [NUM_PORTS] ();

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
		end else if (ce && reg_wr && reg_addr == ADDR_SPACE_PORT) begin
			ctrl_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			offset_q <= OFFSET_RESET;
		end else if (ce && reg_wr && reg_addr == ADDR_BYTE_OFFSET) begin
			offset_q <= reg_wdata;
		end
	end

	// Any other space or port leaves the data byte inert rather than aliasing
	assign space_ok = (ctrl_q[SPACE_HI:SPACE_LO] == SPACE_EEE);
	assign port_sel = ctrl_q[PORT_HI:0];
	assign port_ok = (port_sel >= PORT_FIRST) && (port_sel <= PORT_LAST);
	assign data_wr = ce && reg_wr && (reg_addr == ADDR_DATA_BYTE) && space_ok
		&& port_ok;

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			localparam logic [3:0] PORT_ID = 4'(g) + PORT_FIRST;
			assign pif[g].wr_hi = data_wr && (port_sel == PORT_ID)
				&& (offset_q == OFS_TX_HI);
			assign pif[g].wr_lo = data_wr && (port_sel == PORT_ID)
				&& (offset_q == OFS_TX_LO);
			assign pif[g].wdata = reg_wdata;
			assign tx_words[g] = pif[g].tx_word;
			assign rx_words[g] = pif[g].rx_word;
			assign tx_page[g*WORD_W +: WORD_W] = pif[g].tx_word;
			// Toggle masked out: a negotiation event may move it at any time
			assign tx_fields[g*WORD_W +: WORD_W] = {
				pif[g].tx_word[WORD_W-1:TOGGLE_BIT+1], 1'b0,
				pif[g].tx_word[TOGGLE_BIT-1:0]};
			np_port_regs np_port_regs_i (
				.clock(clock),
				.rstn(rstn),
				.ce(ce),
				.bus(pif[g]),
				.base_sent(base_sent[g]),
				.base_toggle(base_toggle[g]),
				.page_sent(page_sent[g]),
				.partner_load(partner_load[g]),
				.partner_word(partner_word[g*WORD_W +: WORD_W])
			);
		end
	endgenerate

	always_comb begin
		sel_tx = TX_RESET;
		sel_rx = RX_RESET;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (port_sel == 4'(i) + PORT_FIRST) begin
				sel_tx = tx_words[i];
				sel_rx = rx_words[i];
			end
		end
	end

	always_comb begin
		indirect_byte = READ_ZERO;
		if (space_ok && port_ok) begin
			unique case (offset_q)
				OFS_TX_HI: indirect_byte = sel_tx[WORD_W-1:HI_BASE];
				OFS_TX_LO: indirect_byte = sel_tx[HI_BASE-1:0];
				OFS_RX_HI: indirect_byte = sel_rx[WORD_W-1:HI_BASE];
				OFS_RX_LO: indirect_byte = sel_rx[HI_BASE-1:0];
				default: indirect_byte = READ_ZERO;
			endcase
		end
	end

	// Unmapped addresses answer zero so software never sees stale data
	always_comb begin
		unique case (reg_addr)
			ADDR_SPACE_PORT: rdata_d = ctrl_q;
			ADDR_BYTE_OFFSET: rdata_d = offset_q;
			ADDR_DATA_BYTE: rdata_d = indirect_byte;
			default: rdata_d = READ_ZERO;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			rdata_q <= READ_ZERO;
		end else if (ce && reg_rd) begin
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
		end else if (ce) begin
			rvalid_q <= reg_rd;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

	property p_ctrl_store;
		@(posedge clock) disable iff (!rstn)
		(ce && reg_wr && reg_addr == ADDR_SPACE_PORT) ##1 (ce && reg_rd
			&& reg_addr == ADDR_SPACE_PORT) |=> (reg_rdata == $past(reg_wdata, 2));
	endproperty
	a_ctrl_store: assert property (p_ctrl_store)
		else $error("control byte did not read back");

	property p_bad_space_no_write;
		@(posedge clock) disable iff (!rstn)
		(reg_wr && reg_addr == ADDR_DATA_BYTE && !space_ok) |=>
			$stable(tx_fields);
	endproperty
	a_bad_space_no_write: assert property (p_bad_space_no_write)
		else $error("write landed outside the EEE space");

	property p_bad_port_no_write;
		@(posedge clock) disable iff (!rstn)
		(reg_wr && reg_addr == ADDR_DATA_BYTE && !port_ok) |=>
			$stable(tx_fields);
	endproperty
	a_bad_port_no_write: assert property (p_bad_port_no_write)
		else $error("write landed on an invalid port");

	property p_hi_write;
		@(posedge clock) disable iff (!rstn)
		(data_wr && offset_q == OFS_TX_HI) |=>
			(sel_tx[MORE_BIT] == $past(reg_wdata[MORE_BIT-HI_BASE])
			&& sel_tx[TYPE_BIT] == $past(reg_wdata[TYPE_BIT-HI_BASE])
			&& sel_tx[COMPLY_BIT] == $past(reg_wdata[COMPLY_BIT-HI_BASE]));
	endproperty
	a_hi_write: assert property (p_hi_write)
		else $error("upper byte write not applied");

	property p_lo_write;
		@(posedge clock) disable iff (!rstn)
		(data_wr && offset_q == OFS_TX_LO) |=>
			(sel_tx[HI_BASE-1:0] == $past(reg_wdata));
	endproperty
	a_lo_write: assert property (p_lo_write)
		else $error("lower byte write not applied");

	property p_rx_readonly;
		@(posedge clock) disable iff (!rstn)
		(data_wr && (offset_q == OFS_RX_HI || offset_q == OFS_RX_LO)) |=>
			$stable(tx_fields);
	endproperty
	a_rx_readonly: assert property (p_rx_readonly)
		else $error("receive offset write changed transmit word");

	property p_read_answer;
		@(posedge clock) disable iff (!rstn)
		(ce && reg_rd && reg_addr == ADDR_DATA_BYTE && space_ok && port_ok
			&& offset_q == OFS_RX_LO) |=>
			(reg_rvalid && reg_rdata == $past(sel_rx[HI_BASE-1:0]));
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("data byte read returned wrong byte");

	property p_reset_value;
		@(posedge clock)
		!rstn |=> (tx_page[WORD_W-1:0] == TX_RESET);
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("transmit word reset value wrong");

	property p_offset_store;
		@(posedge clock) disable iff (!rstn)
		(ce && reg_wr && reg_addr == ADDR_BYTE_OFFSET) |=>
			(offset_q == $past(reg_wdata));
	endproperty
	a_offset_store: assert property (p_offset_store)
		else $error("offset byte not stored");

	property p_code_hi_write;
		@(posedge clock) disable iff (!rstn)
		(data_wr && offset_q == OFS_TX_HI) |=>
			(sel_tx[CODE_W-1:HI_BASE] == $past(reg_wdata[CODE_W-1-HI_BASE:0]));
	endproperty
	a_code_hi_write: assert property (p_code_hi_write)
		else $error("code field upper bits not written");

	property p_tx_lo_read;
		@(posedge clock) disable iff (!rstn)
		(ce && reg_rd && reg_addr == ADDR_DATA_BYTE && space_ok && port_ok
			&& offset_q == OFS_TX_LO) |=>
			(reg_rdata == $past(sel_tx[HI_BASE-1:0]));
	endproperty
	a_tx_lo_read: assert property (p_tx_lo_read)
		else $error("transmit lower byte read wrong");

	property p_rx_hi_read;
		@(posedge clock) disable iff (!rstn)
		(ce && reg_rd && reg_addr == ADDR_DATA_BYTE && space_ok && port_ok
			&& offset_q == OFS_RX_HI) |=>
			(reg_rdata == $past(sel_rx[WORD_W-1:HI_BASE]));
	endproperty
	a_rx_hi_read: assert property (p_rx_hi_read)
		else $error("receive upper byte read wrong");

	property p_bad_select_read;
		@(posedge clock) disable iff (!rstn)
		(ce && reg_rd && reg_addr == ADDR_DATA_BYTE && !(space_ok && port_ok))
			|=> (reg_rdata == READ_ZERO);
	endproperty
	a_bad_select_read: assert property (p_bad_select_read)
		else $error("bad space or port read not zero");

	property p_unmapped_read;
		@(posedge clock) disable iff (!rstn)
		(ce && reg_rd && reg_addr != ADDR_SPACE_PORT
			&& reg_addr != ADDR_BYTE_OFFSET && reg_addr != ADDR_DATA_BYTE)
			|=> (reg_rdata == READ_ZERO);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped address read not zero");

	property p_rvalid_pulse;
		@(posedge clock) disable iff (!rstn)
		(ce && reg_rd) |=> reg_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse)
		else $error("read not answered");

	property p_rvalid_idle;
		@(posedge clock) disable iff (!rstn)
		(ce && !reg_rd) |=> !reg_rvalid;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle)
		else $error("read valid without a read");

	property p_rdata_hold;
		@(posedge clock) disable iff (!rstn)
		!(ce && reg_rd) |=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without a read");

	property p_ce_freeze;
		@(posedge clock) disable iff (!rstn)
		!ce |=> ($stable(ctrl_q) && $stable(offset_q) && $stable(tx_page)
			&& $stable(reg_rdata) && $stable(reg_rvalid));
	endproperty
	a_ce_freeze: assert property (p_ce_freeze)
		else $error("state moved while clock enable low");
endmodule : eee_np_indirect
`default_nettype wire

// [testbench/eee_np_indirect_tb.sv]
// Self-checking bench for the EEE next page indirect register bank.
// Assumes the design package is compiled first; one 25 MHz core clock.
`timescale 1ns/100ps
`default_nettype none
module eee_np_indirect_tb;
	import eee_np_pkg::*;
	logic clock;
	logic rstn;
	logic ce;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [3:0] base_sent;
	logic [3:0] base_toggle;
	logic [3:0] page_sent;
	logic [3:0] partner_load;
	logic [63:0] partner_word;
	logic [63:0] tx_page;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	eee_np_indirect eee_np_indirect_i (
		.clock(clock), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.base_sent(base_sent), .base_toggle(base_toggle),
		.page_sent(page_sent), .partner_load(partner_load),
		.partner_word(partner_word), .tx_page(tx_page)
	);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic summarize();
		$display("checks %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	// Whole run needs a few hundred cycles; a hang is stopped at cycle 5000, well above this
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// Answer lands on the taking edge itself; rvalid stays up for exactly one cycle
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		check("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
		check(what, {8'h00, reg_rdata}, {8'h00, exp});
		@(negedge clock);
		check("rvalid drop", {15'h0000, reg_rvalid}, 16'h0000);
	endtask : rdchk

	// Control and offset rewritten before each group of data accesses
	task automatic sel(input logic [7:0] ctrl, input logic [7:0] ofs);
		wr(ADDR_SPACE_PORT, ctrl);
		wr(ADDR_BYTE_OFFSET, ofs);
	endtask : sel

	task automatic reset_values();
		@(negedge clock);
		check("tx1", tx_page[15:0], 16'h2001);
		check("tx4", tx_page[63:48], 16'h2001);
		check("tx2 usable", tx_page[31:16], TX_RESET);
		check("rvalid idle", {15'h0000, reg_rvalid}, 16'h0000);
		rdchk(8'h6E, 8'h00, "ctrl reset");
		sel(8'h24, 8'h0E);
		rdchk(ADDR_DATA_BYTE, 8'h20, "tx hi reset");
		sel(8'h24, 8'h0F);
		rdchk(ADDR_DATA_BYTE, 8'h01, "tx lo reset");
		sel(8'h24, 8'h10);
		rdchk(ADDR_DATA_BYTE, 8'h00, "rx hi reset");
		rdchk(8'h6F, 8'h10, "offset readback");
	endtask : reset_values

	task automatic write_ports();
		for (int p = 1; p <= 4; p++) begin
			sel({4'h2, 4'(p)}, 8'h0E);
			wr(ADDR_DATA_BYTE, 8'hFF);
			rdchk(ADDR_DATA_BYTE, 8'hB7, "tx hi write");
			sel({4'h2, 4'(p)}, 8'h0F);
			wr(ADDR_DATA_BYTE, 8'h5A ^ 8'(p));
			rdchk(ADDR_DATA_BYTE, 8'h5A ^ 8'(p), "tx lo write");
			@(negedge clock);
			check("tx word", tx_page[(p-1)*16 +: 16],
				{8'hB7, 8'h5A ^ 8'(p)});
		end
		// Flags must clear as well as set
		sel(8'h21, 8'h0E);
		wr(ADDR_DATA_BYTE, 8'h00);
		@(negedge clock);
		check("tx1 cleared", tx_page[15:0], 16'h005B);
	endtask : write_ports

	task automatic refusals();
		logic [7:0] bad [4] = '{8'h41, 8'h20, 8'h25, 8'hE1};
		foreach (bad[i]) begin
			sel(bad[i], 8'h0E);
			wr(ADDR_DATA_BYTE, 8'h11);
			rdchk(ADDR_DATA_BYTE, 8'h00, "bad select read");
		end
		@(negedge clock);
		check("tx1 kept", tx_page[15:0], 16'h005B);
		sel(8'h21, 8'h10);
		wr(ADDR_DATA_BYTE, 8'h77);
		rdchk(ADDR_DATA_BYTE, 8'h00, "rx read only");
		sel(8'h21, 8'h12);
		rdchk(ADDR_DATA_BYTE, 8'h00, "unused offset");
		wr(8'h55, 8'hAA);
		rdchk(8'h55, 8'h00, "unmapped");
	endtask : refusals

	task automatic hold_off();
		sel(8'h21, 8'h0F);
		@(posedge clock);
		ce <= 1'b0;
		wr(ADDR_DATA_BYTE, 8'hC0);
		@(posedge clock);
		ce <= 1'b1;
		rdchk(ADDR_DATA_BYTE, 8'h5B, "ce frozen");
	endtask : hold_off

	task automatic toggle_seq();
		@(posedge clock);
		base_sent <= 4'h2;
		base_toggle <= 4'h0;
		@(posedge clock);
		base_sent <= 4'h0;
		@(negedge clock);
		check("first toggle", {15'h0000, tx_page[27]}, 16'h0001);
		@(posedge clock);
		page_sent <= 4'h2;
		@(posedge clock);
		page_sent <= 4'h0;
		@(negedge clock);
		check("next toggle", {15'h0000, tx_page[27]}, 16'h0000);
		sel(8'h22, 8'h0E);
		wr(ADDR_DATA_BYTE, 8'hBF);
		rdchk(ADDR_DATA_BYTE, 8'hB7, "toggle read only");
		// Base and next page in one cycle: base codeword wins
		@(posedge clock);
		base_sent <= 4'h2;
		base_toggle <= 4'h2;
		page_sent <= 4'h2;
		@(posedge clock);
		base_sent <= 4'h0;
		page_sent <= 4'h0;
		@(negedge clock);
		check("base wins", {15'h0000, tx_page[27]}, 16'h0000);
	endtask : toggle_seq

	task automatic partner_seq();
		@(posedge clock);
		partner_word <= 64'h0000_C3A5_0000_0000;
		partner_load <= 4'h4;
		@(posedge clock);
		partner_load <= 4'h0;
		partner_word <= 64'h0000_1234_0000_0000;
		sel(8'h23, 8'h10);
		rdchk(ADDR_DATA_BYTE, 8'hC3, "rx hi");
		sel(8'h23, 8'h11);
		rdchk(ADDR_DATA_BYTE, 8'hA5, "rx lo");
	endtask : partner_seq

	// Read straight after a write, no idle cycle between them
	task automatic back_to_back();
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= ADDR_SPACE_PORT;
		reg_wdata <= 8'h22;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		check("b2b rvalid", {15'h0000, reg_rvalid}, 16'h0001);
		check("ctrl next cycle", {8'h00, reg_rdata}, 16'h0022);
	endtask : back_to_back

	// Mid-run reset must undo every write and every captured word
	task automatic reset_again();
		@(posedge clock);
		rstn <= 1'b0;
		@(posedge clock);
		rstn <= 1'b1;
		@(negedge clock);
		check("tx1 again", tx_page[15:0], TX_RESET);
		check("tx2 again", tx_page[31:16], TX_RESET);
		rdchk(ADDR_SPACE_PORT, CTRL_RESET, "ctrl again");
		sel(8'h23, 8'h10);
		rdchk(ADDR_DATA_BYTE, 8'h00, "rx again");
	endtask : reset_again

	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		base_sent = 4'h0;
		base_toggle = 4'h0;
		page_sent = 4'h0;
		partner_load = 4'h0;
		partner_word = 64'h0000_0000_0000_0000;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		reset_values();
		write_ports();
		refusals();
		hold_off();
		toggle_seq();
		partner_seq();
		back_to_back();
		reset_again();
		summarize();
	end
endmodule : eee_np_indirect_tb
`default_nettype wire
